// File: logic/adc_mode_regs.svh
// Purpose: offsets, field positions, reset values and timing counts of the mode register bank
// Assumes: byte address is four times the register index
// Notes:   definitions only
//
// What this block does
// - register-map integrity check enable, resets to 0, 1 turns checking on
// - input-frame check enable, resets to 0, 1 checks received frames
// - one polynomial bit for all checks: 0 selects CCITT-16, 1 selects ANSI-16
// - reset-occurred reads 1 after reset; writing 0 clears status indication
// - word size: 00=16, 01=24 default, 10=32 zero pad, 11=32 sign extend
// - serial timeout enable resets to 1; writing 0 disables the timeout
// - ready source: 00 most lagging, 01 OR of enabled, 1x most leading channel
// - ready pin idles high when float bit is 0, released when 1
// - data available: pin low and held if format 0, fixed low pulse if 1
`ifndef ADC_MODE_REGS_SVH
`define ADC_MODE_REGS_SVH

// ****************************************
// register indices
// ****************************************
`define STATUS_IDX        6'h01
`define MODE_IDX          6'h02

// ****************************************
// mode register fields
// ****************************************
`define MODE_MAP_CRC_BIT  13
`define MODE_RX_CRC_BIT   12
`define MODE_POLY_BIT     11
`define MODE_RST_BIT      10
`define MODE_WSIZE_LSB    8
`define MODE_TIMEOUT_BIT  4
`define MODE_RSRC_LSB     2
`define MODE_FLOAT_BIT    1
`define MODE_FMT_BIT      0
`define MODE_WR_MASK      16'h3F1F
`define MODE_RESET        16'h0510

// ****************************************
// status register fields
// ****************************************
`define STAT_POLY_BIT     11
`define STAT_RST_BIT      10
`define STAT_WSIZE_LSB    8
`define STAT_READY_LSB    0

// ****************************************
// encodings
// ****************************************
`define WSIZE_16          2'h0
`define WSIZE_24          2'h1
`define WSIZE_32_PAD      2'h2
`define WSIZE_32_SIGN     2'h3
`define RSRC_LAG          2'h0
`define RSRC_OR           2'h1

// ****************************************
// timing
// ****************************************
`define CLK_MHZ           200
`define READY_PULSE_NS    20
`define READY_PULSE_CYC   ((`READY_PULSE_NS * `CLK_MHZ + 999) / 1000)

`endif

// File: logic/adc_mode_pkg.sv
// Purpose: shared types of the mode register bank
// Assumes: constants live in adc_mode_regs.svh
// Notes:   two converter channels
package adc_mode_pkg;
  typedef logic [1:0]  word_sel_t;
  typedef logic [1:0]  ready_src_t;
  typedef logic [1:0]  chan_vec_t;
  typedef logic [15:0] reg_word_t;
  typedef enum logic [1:0] {PIN_IDLE, PIN_LOW, PIN_HOLD} pin_state_t;
endpackage

// File: logic/ready_sync_if.sv
// Purpose: carries channel ready levels into the sampling domain
// Assumes: raw levels come from the converter clock domain
// Notes:   none
`timescale 1ns/1ps
interface ready_sync_if;
  adc_mode_pkg::chan_vec_t raw;
  adc_mode_pkg::chan_vec_t synced;
  modport sync (input raw, output synced);
  modport user (output raw, input synced);
endinterface

// File: logic/ready_sync.sv
// Purpose: two-flop synchroniser for the channel ready levels
// Assumes: ce_in freezes the stages
// Notes:   first stage feeds only the second
`timescale 1ns/1ps
module ready_sync (
  // clock and reset
  input  wire logic  clk_in,
  input  wire logic  rstn_in,
  input  wire logic  ce_in,
  // levels
  ready_sync_if.sync sig
);
  import adc_mode_pkg::*;

  chan_vec_t stage1_ff;
  chan_vec_t stage2_ff;

  // ****************************************
  // per-channel stages
  // ****************************************
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_ch
      always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
          stage1_ff[gi] <= 1'b0;
          stage2_ff[gi] <= 1'b0;
        end else if (ce_in) begin
          stage1_ff[gi] <= sig.raw[gi];
          stage2_ff[gi] <= stage1_ff[gi];
        end
      end
    end
  endgenerate

  assign sig.synced = stage2_ff;
endmodule

// File: logic/adc_mode_bank.sv
// Purpose: mode register bank with ready pin and word formatter
// Assumes: register port on clk_in; channel ready levels asynchronous
// Notes:   status register is read-only
//
// Added by the designer: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`include "adc_mode_regs.svh"
module adc_mode_bank (
  // clock, reset, enable
  input  wire logic                    clk_in,
  input  wire logic                    rstn_in,
  input  wire logic                    ce_in,
  // register port
  input  wire logic [7:0]              addr_in,
  input  wire logic [15:0]             wr_data_in,
  input  wire logic                    wr_in,
  input  wire logic                    rd_in,
  output logic      [15:0]             rd_data_out,
  // converter side
  input  wire adc_mode_pkg::chan_vec_t ch_ready_in,
  input  wire adc_mode_pkg::chan_vec_t ch_enable_in,
  input  wire logic                    data_read_in,
  input  wire logic [23:0]             sample_in,
  input  wire logic                    sample_valid_in,
  // formatted data
  output logic      [31:0]             word_out,
  output logic                         word_valid_out,
  // control outputs
  output logic                         map_check_en_out,
  output logic                         frame_check_en_out,
  output logic                         poly_ansi_out,
  output adc_mode_pkg::word_sel_t      word_size_out,
  output logic                         timeout_en_out,
  output logic                         reset_flag_out,
  // conversion ready pin
  output logic                         conversion_ready_pin_out,
  output logic                         conversion_ready_pin_oe_out
);
  import adc_mode_pkg::*;

  localparam logic [3:0] PULSE_CYC = 4'(`READY_PULSE_CYC);

  // ****************************************
  // declarations
  // ****************************************
  logic       map_check_en_ff;
  logic       frame_check_en_ff;
  logic       poly_ansi_ff;
  logic       reset_flag_ff;
  word_sel_t  word_size_ff;
  logic       timeout_en_ff;
  ready_src_t ready_source_select_ff;
  logic       ready_idle_float_ff;
  logic       ready_pulse_format_ff;
  reg_word_t  rd_data_ff;
  reg_word_t  nxt_rd_data;
  reg_word_t  mode_word;
  reg_word_t  status_word;
  reg_word_t  wr_clean;
  logic       sel_ok;
  logic       mode_wr;
  chan_vec_t  ready_prev_ff;
  chan_vec_t  ready_rise;
  chan_vec_t  pending_ff;
  chan_vec_t  nxt_pending;
  logic       lead_ch_ff;
  logic       avail;
  logic       avail_prev_ff;
  pin_state_t pin_state_ff;
  pin_state_t nxt_pin_state;
  logic [3:0] pulse_cnt_ff;
  logic [31:0] word_ff;
  logic       word_valid_ff;
  logic [31:0] nxt_word;

  ready_sync_if rsync ();

  // ****************************************
  // synchroniser
  // ****************************************
  assign rsync.raw = ch_ready_in;

  ready_sync u_sync (
    .clk_in  (clk_in),
    .rstn_in (rstn_in),
    .ce_in   (ce_in),
    .sig     (rsync.sync)
  );

  // ****************************************
  // address decode
  // ****************************************
  assign sel_ok   = (addr_in[1:0] == 2'h0);
  assign mode_wr  = wr_in && sel_ok && (addr_in[7:2] == `MODE_IDX);
  assign wr_clean = wr_data_in & `MODE_WR_MASK;

  // ****************************************
  // mode register fields
  // ****************************************
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      map_check_en_ff   <= 1'b0;
      frame_check_en_ff <= 1'b0;
    end else if (ce_in && mode_wr) begin
      map_check_en_ff   <= wr_clean[`MODE_MAP_CRC_BIT];
      frame_check_en_ff <= wr_clean[`MODE_RX_CRC_BIT];
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      poly_ansi_ff <= 1'b0;
    end else if (ce_in && mode_wr) begin
      poly_ansi_ff <= wr_clean[`MODE_POLY_BIT];
    end
  end

  // writing 1 leaves the flag alone; only a real reset sets it
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      reset_flag_ff <= 1'b1;
    end else if (ce_in && mode_wr && !wr_clean[`MODE_RST_BIT]) begin
      reset_flag_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      word_size_ff <= `WSIZE_24;
    end else if (ce_in && mode_wr) begin
      word_size_ff <= wr_clean[`MODE_WSIZE_LSB +: 2];
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      timeout_en_ff <= 1'b1;
    end else if (ce_in && mode_wr) begin
      timeout_en_ff <= wr_clean[`MODE_TIMEOUT_BIT];
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ready_source_select_ff <= `RSRC_LAG;
      ready_idle_float_ff    <= 1'b0;
      ready_pulse_format_ff  <= 1'b0;
    end else if (ce_in && mode_wr) begin
      ready_source_select_ff <= wr_clean[`MODE_RSRC_LSB +: 2];
      ready_idle_float_ff    <= wr_clean[`MODE_FLOAT_BIT];
      ready_pulse_format_ff  <= wr_clean[`MODE_FMT_BIT];
    end
  end

  // ****************************************
  // readback
  // ****************************************
  always_comb begin
    mode_word                              = 16'h0000;
    mode_word[`MODE_MAP_CRC_BIT]           = map_check_en_ff;
    mode_word[`MODE_RX_CRC_BIT]            = frame_check_en_ff;
    mode_word[`MODE_POLY_BIT]              = poly_ansi_ff;
    mode_word[`MODE_RST_BIT]               = reset_flag_ff;
    mode_word[`MODE_WSIZE_LSB +: 2]        = word_size_ff;
    mode_word[`MODE_TIMEOUT_BIT]           = timeout_en_ff;
    mode_word[`MODE_RSRC_LSB +: 2]         = ready_source_select_ff;
    mode_word[`MODE_FLOAT_BIT]             = ready_idle_float_ff;
    mode_word[`MODE_FMT_BIT]               = ready_pulse_format_ff;
  end

  always_comb begin
    status_word                            = 16'h0000;
    status_word[`STAT_POLY_BIT]            = poly_ansi_ff;
    status_word[`STAT_RST_BIT]             = reset_flag_ff;
    status_word[`STAT_WSIZE_LSB +: 2]      = word_size_ff;
    status_word[`STAT_READY_LSB +: 2]      = pending_ff;
  end

  always_comb begin
    nxt_rd_data = 16'h0000;
    if (rd_in && sel_ok) begin
      if (addr_in[7:2] == `MODE_IDX) begin
        nxt_rd_data = mode_word;
      end else if (addr_in[7:2] == `STATUS_IDX) begin
        nxt_rd_data = status_word;
      end
    end
  end

  // read data stand for one cycle only
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rd_data_ff <= 16'h0000;
    end else if (ce_in) begin
      rd_data_ff <= nxt_rd_data;
    end
  end

  // ****************************************
  // channel data tracking
  // ****************************************
  assign ready_rise = rsync.synced & ~ready_prev_ff;

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ready_prev_ff <= 2'h0;
    end else if (ce_in) begin
      ready_prev_ff <= rsync.synced;
    end
  end

  // a new arrival in the clearing cycle survives the clear
  always_comb begin
    nxt_pending = pending_ff;
    if (data_read_in) begin
      nxt_pending = 2'h0;
    end
    nxt_pending = (nxt_pending | (ready_rise & ch_enable_in)) & ch_enable_in;
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pending_ff <= 2'h0;
    end else if (ce_in) begin
      pending_ff <= nxt_pending;
    end
  end

  // first enabled channel to arrive after an empty state leads
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      lead_ch_ff <= 1'b0;
    end else if (ce_in && (pending_ff == 2'h0 || data_read_in)) begin
      if ((ready_rise[0] && ch_enable_in[0]) || !ch_enable_in[1]) begin
        lead_ch_ff <= 1'b0;
      end else if (ready_rise[1]) begin
        lead_ch_ff <= 1'b1;
      end
    end
  end

  // ****************************************
  // ready source
  // ****************************************
  always_comb begin
    avail = 1'b0;
    unique case (ready_source_select_ff)
      `RSRC_LAG: begin
        avail = (ch_enable_in != 2'h0) && ((pending_ff & ch_enable_in) == ch_enable_in);
      end
      `RSRC_OR: begin
        avail = |(pending_ff & ch_enable_in);
      end
      default: begin
        avail = pending_ff[lead_ch_ff] && ch_enable_in[lead_ch_ff];
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      avail_prev_ff <= 1'b0;
    end else if (ce_in) begin
      avail_prev_ff <= avail;
    end
  end

  // ****************************************
  // ready pin sequencer
  // ****************************************
  always_comb begin
    nxt_pin_state = pin_state_ff;
    unique case (pin_state_ff)
      PIN_IDLE: begin
        if (avail && !avail_prev_ff) begin
          nxt_pin_state = PIN_LOW;
        end
      end
      PIN_LOW: begin
        if (ready_pulse_format_ff) begin
          if (pulse_cnt_ff == PULSE_CYC - 4'h1) begin
            nxt_pin_state = PIN_HOLD;
          end
        end else if (!avail) begin
          nxt_pin_state = PIN_IDLE;
        end
      end
      PIN_HOLD: begin
        if (!avail) begin
          nxt_pin_state = PIN_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pin_state_ff <= PIN_IDLE;
    end else if (ce_in) begin
      pin_state_ff <= nxt_pin_state;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pulse_cnt_ff <= 4'h0;
    end else if (ce_in) begin
      if (pin_state_ff == PIN_LOW && ready_pulse_format_ff) begin
        pulse_cnt_ff <= pulse_cnt_ff + 4'h1;
      end else begin
        pulse_cnt_ff <= 4'h0;
      end
    end
  end

  // pin low only in PIN_LOW; otherwise idle high or released
  assign conversion_ready_pin_out    = (pin_state_ff != PIN_LOW);
  assign conversion_ready_pin_oe_out = (pin_state_ff == PIN_LOW) || !ready_idle_float_ff;

  // ****************************************
  // word formatter
  // ****************************************
  always_comb begin
    nxt_word = 32'h00000000;
    unique case (word_size_ff)
      `WSIZE_16: begin
        nxt_word = {16'h0000, sample_in[23:8]};
      end
      `WSIZE_24: begin
        nxt_word = {8'h00, sample_in};
      end
      `WSIZE_32_PAD: begin
        nxt_word = {sample_in, 8'h00};
      end
      `WSIZE_32_SIGN: begin
        nxt_word = {{8{sample_in[23]}}, sample_in};
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      word_ff       <= 32'h00000000;
      word_valid_ff <= 1'b0;
    end else if (ce_in) begin
      word_valid_ff <= sample_valid_in;
      if (sample_valid_in) begin
        word_ff <= nxt_word;
      end
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign rd_data_out        = rd_data_ff;
  assign word_out           = word_ff;
  assign word_valid_out     = word_valid_ff;
  assign map_check_en_out   = map_check_en_ff;
  assign frame_check_en_out = frame_check_en_ff;
  assign poly_ansi_out      = poly_ansi_ff;
  assign word_size_out      = word_size_ff;
  assign timeout_en_out     = timeout_en_ff;
  assign reset_flag_out     = reset_flag_ff;
endmodule

// File: tb/adc_mode_bank_sva.sv
// Purpose: port assertions for the mode register bank
// Assumes: mode register at byte 8'h08, ce_in held high
// Notes:   a shadow of the mode word follows host writes
`timescale 1ns/1ps
module adc_mode_bank_sva (
  // clock and reset
  input wire logic                    clk_in,
  input wire logic                    rstn_in,
  input wire logic                    ce_in,
  // register port
  input wire logic [7:0]              addr_in,
  input wire logic [15:0]             wr_data_in,
  input wire logic                    wr_in,
  input wire logic                    rd_in,
  input wire logic [15:0]             rd_data_out,
  // converter side
  input wire logic                    data_read_in,
  input wire logic                    sample_valid_in,
  input wire logic                    word_valid_out,
  // fields and pin
  input wire logic                    map_check_en_out,
  input wire logic                    frame_check_en_out,
  input wire logic                    poly_ansi_out,
  input wire adc_mode_pkg::word_sel_t word_size_out,
  input wire logic                    timeout_en_out,
  input wire logic                    reset_flag_out,
  input wire logic                    conversion_ready_pin_out,
  input wire logic                    conversion_ready_pin_oe_out
);
  import adc_mode_pkg::*;
  reg_word_t mode_ff;
  wire       drv_low = conversion_ready_pin_oe_out & ~conversion_ready_pin_out;

  // reset flag is only ever cleared by the host
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      mode_ff <= 16'h0510;
    end else if (ce_in && wr_in && addr_in == 8'h08) begin
      mode_ff <= (wr_data_in & 16'h3B1F) | (wr_data_in & mode_ff & 16'h0400);
    end
  end

  default clocking @(posedge clk_in);
  endclocking
  default disable iff (!rstn_in);

  sequence s_mode_read;
    rd_in && ce_in && addr_in == 8'h08;
  endsequence
  sequence s_pulse4;
    drv_low [*4] ##1 !drv_low;
  endsequence
  sequence s_hold3;
    (drv_low && !mode_ff[0] && !data_read_in) [*3];
  endsequence

  chk_map_enable: assert property (map_check_en_out == mode_ff[13])
    else $error("map check enable differs");
  chk_frame_enable: assert property (frame_check_en_out == mode_ff[12])
    else $error("frame check enable differs");
  chk_poly_select: assert property (poly_ansi_out == mode_ff[11])
    else $error("polynomial select differs");
  chk_reset_flag: assert property (reset_flag_out == mode_ff[10])
    else $error("reset flag differs");
  chk_word_size: assert property (word_size_out == mode_ff[9:8])
    else $error("word size differs");
  chk_timeout_enable: assert property (timeout_en_out == mode_ff[4])
    else $error("timeout enable differs");
  chk_mode_read: assert property (s_mode_read |=> rd_data_out == $past(mode_ff))
    else $error("mode read data differs");
  chk_read_idle: assert property (ce_in && !rd_in |=> rd_data_out == 16'h0000)
    else $error("read data not zero");
  chk_word_valid: assert property (ce_in |=> word_valid_out == $past(sample_valid_in))
    else $error("word valid timing wrong");
  chk_float_idle: assert property (!conversion_ready_pin_oe_out |-> mode_ff[1])
    else $error("pin released while float off");
  chk_pulse_len: assert property ($rose(drv_low) && mode_ff[0] |-> s_pulse4)
    else $error("ready pulse length wrong");
  chk_level_hold: assert property (s_hold3 |=> drv_low)
    else $error("ready level not held");
endmodule

bind adc_mode_bank adc_mode_bank_sva i_sva (
  .clk_in(clk_in), .rstn_in(rstn_in), .ce_in(ce_in), .addr_in(addr_in),
  .wr_data_in(wr_data_in), .wr_in(wr_in), .rd_in(rd_in), .rd_data_out(rd_data_out),
  .data_read_in(data_read_in), .sample_valid_in(sample_valid_in), .word_valid_out(word_valid_out),
  .map_check_en_out(map_check_en_out), .frame_check_en_out(frame_check_en_out),
  .poly_ansi_out(poly_ansi_out), .word_size_out(word_size_out), .timeout_en_out(timeout_en_out),
  .reset_flag_out(reset_flag_out), .conversion_ready_pin_out(conversion_ready_pin_out),
  .conversion_ready_pin_oe_out(conversion_ready_pin_oe_out)
);

// File: tb/adc_source.sv
// Purpose: converter-side model raising channel ready levels
// Assumes: go_in rises once per frame, mask_in steady meanwhile
// Notes:   link clock of 80 ns runs only within a frame
`timescale 1ns/1ps
module adc_source (
  // control
  input  wire logic                    go_in,
  input  wire adc_mode_pkg::chan_vec_t mask_in,
  // ready levels
  output adc_mode_pkg::chan_vec_t      ready_out
);
  import adc_mode_pkg::*;
  logic link_clk;

  initial begin
    link_clk = 1'b0;
    ready_out = 2'h0;
  end

  // ready rises and falls on link clock edges
  always @(posedge go_in) begin
    // step off the clock edge so ready never moves on a sampling edge
    #1;
    for (int k = 0; k < 8; k++) begin
      #40 link_clk = ~link_clk;
      if (k == 2) ready_out = mask_in;
      if (k == 6) ready_out = 2'h0;
    end
  end
endmodule

// File: tb/adc_mode_bank_bench.sv
// Purpose: self-checking bench of the mode register bank
// Assumes: ce_in held high except for one dropped write in t_fields, mode at 8'h08, status at 8'h04
// Notes:   ready levels come from the converter model
`timescale 1ns/1ps
module adc_mode_bank_bench;
  import adc_mode_pkg::*;
  logic        clk_in, rstn_in, ce_in, wr_in, rd_in, data_read_in, sample_valid_in, go;
  logic [7:0]  addr_in;
  logic [15:0] wr_data_in, rd_data;
  logic [23:0] sample_in;
  logic [31:0] word;
  logic        word_valid, map_en, frame_en, poly, timeout_en, rst_flag, pin, pin_oe;
  word_sel_t   wsize;
  chan_vec_t   go_mask, ch_ready, ch_enable_in;
  int          err_total, n_tests, cycles;
  logic [31:0] fexp [4] = '{32'h00008ABC, 32'h008ABCDE, 32'h8ABCDE00, 32'hFF8ABCDE};
  wire         drv_low = pin_oe & ~pin;

  adc_mode_bank i_dut (
    .clk_in(clk_in), .rstn_in(rstn_in), .ce_in(ce_in), .addr_in(addr_in), .wr_data_in(wr_data_in),
    .wr_in(wr_in), .rd_in(rd_in), .rd_data_out(rd_data), .ch_ready_in(ch_ready),
    .ch_enable_in(ch_enable_in), .data_read_in(data_read_in), .sample_in(sample_in),
    .sample_valid_in(sample_valid_in), .word_out(word), .word_valid_out(word_valid),
    .map_check_en_out(map_en), .frame_check_en_out(frame_en), .poly_ansi_out(poly),
    .word_size_out(wsize), .timeout_en_out(timeout_en), .reset_flag_out(rst_flag),
    .conversion_ready_pin_out(pin), .conversion_ready_pin_oe_out(pin_oe)
  );
  adc_source i_src (.go_in(go), .mask_in(go_mask), .ready_out(ch_ready));

  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end

  // ****************************************
  // helpers
  // ****************************************
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_fields(input logic [8:0] exp);
    chk({23'h0, map_en, frame_en, poly, wsize, timeout_en, rst_flag, pin, pin_oe}, {23'h0, exp});
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    addr_in <= a;
    wr_data_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    @(negedge clk_in);
    chk({16'h0, rd_data}, {16'h0, exp});
    @(posedge clk_in);
  endtask
  task automatic fire(input chan_vec_t m);
    cyc(80);
    go_mask <= m;
    go <= 1'b1;
    @(posedge clk_in);
    go <= 1'b0;
  endtask
  task automatic wait_low();
    int n;
    n = 0;
    do begin
      @(negedge clk_in);
      n++;
    end while (n < 200 && drv_low !== 1'b1);
    chk({31'h0, drv_low}, 1);
  endtask
  task automatic consume(input logic oe_exp);
    data_read_in <= 1'b1;
    @(posedge clk_in);
    data_read_in <= 1'b0;
    cyc(1);
    @(negedge clk_in);
    chk({30'h0, pin | ~pin_oe, pin_oe}, {30'h0, 1'b1, oe_exp});
    @(posedge clk_in);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    @(negedge clk_in);
    chk_fields(9'b000011111);
    @(posedge clk_in);
    rd_chk(8'h08, 16'h0510);
    rd_chk(8'h04, 16'h0500);
  endtask
  task automatic t_fields();
    logic [1:0]  s;
    logic [15:0] v;
    wr(8'h08, 16'h3F1F);
    rd_chk(8'h08, 16'h3F1F);
    for (int i = 0; i < 4; i++) begin
      s = i[1:0];
      v = {2'b00, s[0], s[1], s[0], 1'b0, s, 3'b000, ~s[0], 4'h0};
      wr(8'h08, v);
      @(negedge clk_in);
      chk_fields({s[0], s[1], s[0], s, ~s[0], 3'b011});
      @(posedge clk_in);
      rd_chk(8'h08, v);
    end
    wr(8'h08, 16'h0400);
    rd_chk(8'h08, 16'h0000);
    rd_chk(8'h04, 16'h0000);
    wr(8'h04, 16'hFFFF);
    rd_chk(8'h04, 16'h0000);
    rd_chk(8'h0C, 16'h0000);
    rd_chk(8'h09, 16'h0000);
    ce_in <= 1'b0;
    wr(8'h08, 16'h0010);
    ce_in <= 1'b1;
    rd_chk(8'h08, 16'h0000);
  endtask
  task automatic t_format();
    for (int i = 0; i < 4; i++) begin
      wr(8'h08, {6'h00, i[1:0], 8'h10});
      sample_in <= 24'h8ABCDE;
      sample_valid_in <= 1'b1;
      @(posedge clk_in);
      sample_valid_in <= 1'b0;
      @(negedge clk_in);
      chk({31'h0, word_valid}, 1);
      chk(word, fexp[i]);
      @(posedge clk_in);
    end
  endtask
  task automatic t_ready();
    int m;
    wr(8'h08, 16'h0014);
    fire(2'h1);
    wait_low();
    rd_chk(8'h04, 16'h0001);
    cyc(10);
    @(negedge clk_in);
    chk({31'h0, drv_low}, 1);
    @(posedge clk_in);
    consume(1'b1);
    wr(8'h08, 16'h0010);
    fire(2'h1);
    cyc(80);
    @(negedge clk_in);
    chk({31'h0, drv_low}, 0);
    @(posedge clk_in);
    fire(2'h2);
    wait_low();
    @(posedge clk_in);
    consume(1'b1);
    for (int s = 2; s < 4; s++) begin
      wr(8'h08, 16'h0010 | (s[15:0] << 2));
      fire(2'h2);
      wait_low();
      @(posedge clk_in);
      consume(1'b1);
    end
    ch_enable_in <= 2'h1;
    wr(8'h08, 16'h0014);
    fire(2'h2);
    cyc(80);
    @(negedge clk_in);
    chk({31'h0, drv_low}, 0);
    @(posedge clk_in);
    ch_enable_in <= 2'h3;
    wr(8'h08, 16'h0017);
    @(negedge clk_in);
    chk({31'h0, pin_oe}, 0);
    @(posedge clk_in);
    fire(2'h1);
    wait_low();
    m = 0;
    while (drv_low === 1'b1 && m < 20) begin
      m++;
      @(negedge clk_in);
    end
    chk(m, 4);
    @(posedge clk_in);
    consume(1'b0);
  endtask

  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 6000) begin
      err_total++;
      stop_test();
    end
  end

  initial begin
    rstn_in = 1'b0;
    ce_in = 1'b1;
    addr_in = 8'h00;
    wr_data_in = 16'h0000;
    wr_in = 1'b0;
    rd_in = 1'b0;
    data_read_in = 1'b0;
    sample_in = 24'h000000;
    sample_valid_in = 1'b0;
    ch_enable_in = 2'h3;
    go = 1'b0;
    go_mask = 2'h0;
    repeat (2) @(posedge clk_in);
    rstn_in <= 1'b1;
    @(posedge clk_in);
    t_reset();
    t_fields();
    t_format();
    t_ready();
    stop_test();
  end
endmodule
